// file: common/spi_cs_pkg.sv
`default_nettype none
package spi_cs_pkg;
   // word, divider and buffer shape
   localparam int WORD_W     = 8;
   localparam int DIV_W      = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int BITS_W     = $clog2(WORD_W + 1);
   // the one mode this port supports: half-cycle delay, idle-low clock
   localparam logic [1:0] STOP_MODE_HALF   = 2'h3;
   localparam logic       CLK_POL_IDLE_LOW = 1'h0;
   localparam logic       FRAME_POL_LOW    = 1'h1;
   localparam logic       SRC_INTERNAL     = 1'h1;
   localparam logic [7:0] SLAVE_DIV        = 8'h01;
   // system clocks per internal sample-rate period (S = 2P)
   localparam int SYS_PER_S = 2;
   // synchroniser bit positions
   localparam int PIN_N    = 5;
   localparam int PIN_SCLK = 4;
   localparam int PIN_TX_FRAME = 3;
   localparam int PIN_RX_FRAME = 2;
   localparam int PIN_DIN  = 1;
   localparam int PIN_EXT  = 0;
   // idle pin levels: clock low, both active-low frame pins high
   localparam logic [PIN_N-1:0] PIN_IDLE = 5'h0C;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD_H,
      ST_LEAD_L,
      ST_HIGH,
      ST_LOW,
      ST_TRAIL,
      ST_SLAVE
   } phase_t;

   typedef struct packed {
      logic [1:0]       clock_stop_mode;
      logic             tx_clock_polarity;
      logic             tx_frame_polarity;
      logic             rx_frame_polarity;
      logic             tx_clock_dir;
      logic             tx_frame_dir;
      logic             rx_clock_dir;
      logic             rx_frame_dir;
      logic             srg_clock_source_sel;
      logic [DIV_W-1:0] clock_divide_value;
   } cfg_t;
endpackage : spi_cs_pkg
`default_nettype wire

// file: src/spi_clock_stop_port.sv
`timescale 1ns/1ps
`default_nettype none

// small synchronous fifo; ready on the fill side is a flop
module stream_fifo
   import spi_cs_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] count;
      logic          ready;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t d;
   logic [W-1:0] mem [DEPTH];
   logic         push;
   logic         pop;

   assign push      = in_valid & q.ready;
   assign pop       = out_ready & out_valid;
   assign out_valid = (q.count != '0);
   assign out_data  = mem[q.rd];
   assign in_ready  = q.ready;

   // pointers wrap naturally, so depth must be a power of two
   always_comb begin
      d = q;
      if (push) begin
         d.wr = q.wr + PW'(1);
      end
      if (pop) begin
         d.rd = q.rd + PW'(1);
      end
      if (push & ~pop) begin
         d.count = q.count + CW'(1);
      end else if (pop & ~push) begin
         d.count = q.count - CW'(1);
      end
      d.ready = (d.count != CW'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q       <= '0;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // storage needs no reset; count guards reads
   always_ff @(posedge clk) begin
      if (push) begin
         mem[q.wr] <= in_data;
      end
   end
endmodule : stream_fifo

// Contract
// - internal source gives S of two system clocks, else external clock period.
// - serial clock period equals divider plus one times S.
// - high phase is div/2+1 S when even, (div+1)/2 S when odd or zero.
// - low phase is div/2 S when even, (div+1)/2 S when odd or zero.
// - master drives clock and frame; receive direction bits stay zero.
// - slave needs internal source and divider one, giving half-CPU sample clock.
// - master with frame polarity one drives an active-low select.
// - slave inverts the active-low select on both frame pins before use.
// - master lowers select before the rising edge that starts the transfer.
// - master asserts select one full clock period before first rising edge.
// - master holds select one low phase after final falling edge.
// - transmit data changes after falling serial clock edges.
// - receive data is sampled on rising serial clock edges.
// - master presents first bit one high phase after select goes low.
// - data output released at the falling edge ending the last bit.
module spi_clock_stop_port
   import spi_cs_pkg::*;
#(
   parameter int FIFO_W = WORD_W,
   parameter int FIFO_D = FIFO_DEPTH
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RST_B,
   input  wire cfg_t              CFG,
   input  wire logic [WORD_W-1:0] TX_DATA,
   input  wire logic              TX_VALID,
   output logic                  TX_READY,
   output logic [WORD_W-1:0]     RX_DATA,
   output logic                  RX_VALID,
   input  wire logic              SERIAL_CLOCK_PIN_I,
   output logic                  SERIAL_CLOCK_PIN_O,
   output logic                  SERIAL_CLOCK_PIN_OE_B,
   input  wire logic              TX_FRAME_SELECT_PIN_I,
   output logic                  TX_FRAME_SELECT_PIN_O,
   output logic                  TX_FRAME_SELECT_PIN_OE_B,
   input  wire logic              RX_FRAME_PIN_I,
   output logic                  SERIAL_DATA_OUT_O,
   output logic                  SERIAL_DATA_OUT_OE_B,
   input  wire logic              SERIAL_DATA_IN,
   input  wire logic              SRG_EXT_CLK_IN,
   output logic                  CONFIG_OK,
   output logic                  BUSY
);
   localparam int SW = $clog2(SYS_PER_S);

   typedef struct packed {
      logic [PIN_N-1:0]  sync1;
      logic [PIN_N-1:0]  sync2;
      logic [PIN_N-1:0]  sync3;
      logic [PIN_N-1:0]  stable;
      logic [SW-1:0]     s_cnt;
      phase_t            phase;
      logic [DIV_W:0]    cnt;
      logic [BITS_W-1:0] bits;
      logic [BITS_W-1:0] rx_cnt;
      logic [WORD_W-1:0] tx_sh;
      logic [WORD_W-1:0] rx_sh;
      logic              sel;
      logic              sclk_o;
      logic              sclk_oe_b;
      logic              fs_o;
      logic              fs_oe_b;
      logic              dout;
      logic              dout_oe_b;
      logic [WORD_W-1:0] rx_data;
      logic              rx_valid;
      logic              cfg_ok;
      logic              busy;
   } port_state_t;

   port_state_t       q;
   port_state_t       n;
   logic              f_valid;
   logic [WORD_W-1:0] f_data;
   logic              pop;

   stream_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_tx_fifo (
      .clk       (CLK_SYS),
      .rst_b     (RST_B),
      .in_valid  (TX_VALID),
      .in_ready  (TX_READY),
      .in_data   (TX_DATA),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data)
   );

   // next-state logic of the whole port
   always_comb begin
      logic             s_tick;
      logic             hs_tick;
      logic             expire;
      logic             master;
      logic             ok_mode;
      logic             tx_act;
      logic             rx_act;
      logic             rise;
      logic             fall;
      logic             samp;
      logic             shift;
      logic             load;
      logic [DIV_W:0]   h2;
      logic [DIV_W:0]   l2;
      logic [PIN_N-1:0] upd;
      logic [WORD_W-1:0] rx_next;
      s_tick  = 1'b0;
      hs_tick = 1'b0;
      expire  = 1'b0;
      master  = 1'b0;
      ok_mode = 1'b0;
      tx_act  = 1'b0;
      rx_act  = 1'b0;
      rise    = 1'b0;
      fall    = 1'b0;
      samp    = 1'b0;
      shift   = 1'b0;
      load    = 1'b0;
      h2      = '0;
      l2      = '0;
      upd     = '0;
      rx_next = '0;
      n       = q;
      pop     = 1'b0;
      n.rx_valid = 1'b0;

      // three-stage synchronisers; a change counts when stages two and three agree
      n.sync1 = {SERIAL_CLOCK_PIN_I, TX_FRAME_SELECT_PIN_I, RX_FRAME_PIN_I,
                 SERIAL_DATA_IN, SRG_EXT_CLK_IN};
      n.sync2 = q.sync1;
      n.sync3 = q.sync2;

      // internal sample-rate tick, one per two system clocks
      s_tick  = (q.s_cnt == SW'(SYS_PER_S - 1));
      n.s_cnt = s_tick ? '0 : q.s_cnt + SW'(1);

      // slave clock and frame pins adopted only on the internal sample tick
      upd = ~(q.sync2 ^ q.sync3);
      upd[PIN_SCLK] = upd[PIN_SCLK] & s_tick;
      upd[PIN_TX_FRAME] = upd[PIN_TX_FRAME] & s_tick;
      upd[PIN_RX_FRAME] = upd[PIN_RX_FRAME] & s_tick;
      n.stable = (q.stable & ~upd) | (q.sync3 & upd);

      // half-S tick: every system clock, or each external clock edge
      if (CFG.srg_clock_source_sel == SRC_INTERNAL) begin
         hs_tick = 1'b1;
      end else begin
         hs_tick = n.stable[PIN_EXT] ^ q.stable[PIN_EXT];
      end

      // phase lengths in half-S units; they add to 2*(1+div)
      if ((CFG.clock_divide_value != '0) && !CFG.clock_divide_value[0]) begin
         h2 = {1'b0, CFG.clock_divide_value} + (DIV_W+1)'(2);
         l2 = {1'b0, CFG.clock_divide_value};
      end else begin
         h2 = {1'b0, CFG.clock_divide_value} + (DIV_W+1)'(1);
         l2 = {1'b0, CFG.clock_divide_value} + (DIV_W+1)'(1);
      end

      // only the idle-low, half-delay mode is legal; frame polarity is not checked
      master  = CFG.tx_clock_dir & CFG.tx_frame_dir;
      ok_mode = (CFG.clock_stop_mode == STOP_MODE_HALF)
              & (CFG.tx_clock_polarity == CLK_POL_IDLE_LOW)
              & ~CFG.rx_clock_dir & ~CFG.rx_frame_dir;
      if (!master) begin
         ok_mode = ok_mode & ~CFG.tx_clock_dir & ~CFG.tx_frame_dir
                 & (CFG.srg_clock_source_sel == SRC_INTERNAL)
                 & (CFG.clock_divide_value == SLAVE_DIV);
      end
      n.cfg_ok = ok_mode;

      // slave view of the link after inversion of the frame pins
      tx_act = n.stable[PIN_TX_FRAME] ^ CFG.tx_frame_polarity;
      rx_act = n.stable[PIN_RX_FRAME] ^ CFG.rx_frame_polarity;
      rise   = n.stable[PIN_SCLK] & ~q.stable[PIN_SCLK];
      fall   = ~n.stable[PIN_SCLK] & q.stable[PIN_SCLK];

      // phase countdown in half-S steps
      expire = hs_tick & (q.cnt == (DIV_W+1)'(1));
      if (hs_tick) begin
         n.cnt = q.cnt - (DIV_W+1)'(1);
      end

      if (!q.cfg_ok) begin
         // illegal setup: park everything, pins released
         n.phase  = ST_IDLE;
         n.sel    = 1'b0;
         n.sclk_o = CLK_POL_IDLE_LOW;
         n.dout   = 1'b0;
         n.dout_oe_b = 1'b1;
         n.rx_cnt = '0;
      end else begin
         case (q.phase)
            ST_IDLE: begin
               if (master && f_valid) begin
                  pop     = 1'b1;
                  n.tx_sh = f_data;
                  n.sel   = 1'b1;
                  n.cnt   = h2;
                  n.rx_cnt = '0;
                  n.phase = ST_LEAD_H;
               end else if (!master && tx_act) begin
                  load    = 1'b1;
                  n.rx_cnt = '0;
                  n.phase = ST_SLAVE;
               end
            end
            ST_LEAD_H: begin
               if (expire) begin
                  n.dout      = q.tx_sh[WORD_W-1];
                  n.dout_oe_b = 1'b0;
                  n.bits      = BITS_W'(WORD_W);
                  n.cnt       = l2;
                  n.phase     = ST_LEAD_L;
               end
            end
            ST_LEAD_L: begin
               if (expire) begin
                  n.sclk_o = 1'b1;
                  samp     = 1'b1;
                  n.cnt    = h2;
                  n.phase  = ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (expire) begin
                  n.sclk_o = 1'b0;
                  shift    = 1'b1;
                  n.cnt    = l2;
                  n.phase  = (q.bits == BITS_W'(1)) ? ST_TRAIL : ST_LOW;
               end
            end
            ST_LOW: begin
               if (expire) begin
                  n.sclk_o = 1'b1;
                  samp     = 1'b1;
                  n.cnt    = h2;
                  n.phase  = ST_HIGH;
               end
            end
            ST_TRAIL: begin
               if (expire) begin
                  n.sel   = 1'b0;
                  n.phase = ST_IDLE;
               end
            end
            ST_SLAVE: begin
               if (!tx_act) begin
                  n.dout      = 1'b0;
                  n.dout_oe_b = 1'b1;
                  n.bits      = '0;
                  n.phase     = ST_IDLE;
               end else begin
                  samp  = rise & rx_act;
                  shift = fall & (q.bits != '0);
               end
            end
            default: begin
               n.phase = ST_IDLE;
            end
         endcase
      end

      // slave word load; an empty buffer sends zeros
      if (load) begin
         pop         = f_valid;
         n.tx_sh     = f_valid ? f_data : '0;
         n.dout      = f_valid & f_data[WORD_W-1];
         n.dout_oe_b = 1'b0;
         n.bits      = BITS_W'(WORD_W);
      end

      // next bit goes out after a falling edge; release after the last
      if (shift) begin
         if (q.bits == BITS_W'(1)) begin
            n.dout      = 1'b0;
            n.dout_oe_b = 1'b1;
            n.bits      = '0;
         end else begin
            n.tx_sh = {q.tx_sh[WORD_W-2:0], 1'b0};
            n.dout  = q.tx_sh[WORD_W-2];
            n.bits  = q.bits - BITS_W'(1);
         end
      end

      // capture on the rising edge, msb first
      if (samp) begin
         rx_next = {q.rx_sh[WORD_W-2:0], q.stable[PIN_DIN]};
         n.rx_sh = rx_next;
         if (q.rx_cnt == BITS_W'(WORD_W - 1)) begin
            n.rx_cnt   = '0;
            n.rx_data  = rx_next;
            n.rx_valid = 1'b1;
         end else begin
            n.rx_cnt = q.rx_cnt + BITS_W'(1);
         end
      end

      // pin drivers; enables are low while driving
      n.sclk_oe_b = ~(n.cfg_ok & master & CFG.tx_clock_dir);
      n.fs_oe_b   = ~(n.cfg_ok & master & CFG.tx_frame_dir);
      n.fs_o      = n.sel ^ CFG.tx_frame_polarity;
      n.busy      = (n.phase != ST_IDLE);
   end

   // single state register; reset leaves all pins released
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         q           <= '0;
         q.phase     <= ST_IDLE;
         // pins start at idle levels, else a slave sees a false select
         q.sync1     <= PIN_IDLE;
         q.sync2     <= PIN_IDLE;
         q.sync3     <= PIN_IDLE;
         q.stable    <= PIN_IDLE;
         q.sclk_oe_b <= 1'b1;
         q.fs_o      <= 1'b1;
         q.fs_oe_b   <= 1'b1;
         q.dout_oe_b <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign SERIAL_CLOCK_PIN_O       = q.sclk_o;
   assign SERIAL_CLOCK_PIN_OE_B    = q.sclk_oe_b;
   assign TX_FRAME_SELECT_PIN_O    = q.fs_o;
   assign TX_FRAME_SELECT_PIN_OE_B = q.fs_oe_b;
   assign SERIAL_DATA_OUT_O        = q.dout;
   assign SERIAL_DATA_OUT_OE_B     = q.dout_oe_b;
   assign RX_DATA                  = q.rx_data;
   assign RX_VALID                 = q.rx_valid;
   assign CONFIG_OK                = q.cfg_ok;
   assign BUSY                     = q.busy;
endmodule : spi_clock_stop_port
`default_nettype wire

// file: tb/spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural spi peripheral facing the master port
module spi_peer (
   input  wire logic       sclk,
   input  wire logic       sel_b,
   input  wire logic       mosi,
   input  wire logic [7:0] tx_word,
   output logic           miso,
   output logic [7:0]     got
);
   logic [7:0] sh;
   initial begin
      miso = 1'h0;
      got  = 8'h00;
      sh   = 8'h00;
   end
   // enabled by select, first bit ready well before the first rising edge
   always @(negedge sel_b) begin
      sh   = tx_word;
      miso = sh[7];
   end
   // capture on rising edges while enabled
   always @(posedge sclk) if (!sel_b) got = {got[6:0], mosi};
   // next bit after each falling edge, so it holds through the high phase
   always @(negedge sclk) begin
      if (!sel_b) begin
         sh   = {sh[6:0], 1'h0};
         miso = sh[7];
      end
   end
   // a released line keeps no stale bit: it flips
   always @(posedge sel_b) miso = ~miso;
endmodule : spi_peer
`default_nettype wire

// file: tb/spi_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module spi_port_asserts
   import spi_cs_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire cfg_t CFG,
   input wire logic SERIAL_CLOCK_PIN_O,
   input wire logic SERIAL_CLOCK_PIN_OE_B,
   input wire logic TX_FRAME_SELECT_PIN_O,
   input wire logic TX_FRAME_SELECT_PIN_OE_B,
   input wire logic SERIAL_DATA_OUT_O,
   input wire logic SERIAL_DATA_OUT_OE_B,
   input wire logic RX_VALID,
   input wire logic CONFIG_OK,
   input wire logic BUSY
);
   logic [9:0] lo_cnt, hi_cnt, h2, l2;
   logic [3:0] rises;
   logic       even;
   logic       mst;
   // phase lengths in system clocks; only valid with the internal source
   assign even = !CFG.clock_divide_value[0] && CFG.clock_divide_value != 8'h00;
   assign h2   = {2'h0, CFG.clock_divide_value} + (even ? 10'h002 : 10'h001);
   assign l2   = {2'h0, CFG.clock_divide_value} + (even ? 10'h000 : 10'h001);
   assign mst  = CONFIG_OK && CFG.tx_clock_dir && CFG.srg_clock_source_sel;
   // low run while selected, high run, rising edges in this frame
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         lo_cnt <= 10'h000;
         hi_cnt <= 10'h000;
         rises  <= 4'h0;
      end else begin
         lo_cnt <= (TX_FRAME_SELECT_PIN_O || SERIAL_CLOCK_PIN_O) ? 10'h000 : lo_cnt + 10'h001;
         hi_cnt <= SERIAL_CLOCK_PIN_O ? hi_cnt + 10'h001 : 10'h000;
         rises  <= TX_FRAME_SELECT_PIN_O ? 4'h0
                 : rises + {3'h0, SERIAL_CLOCK_PIN_O && hi_cnt == 10'h000};
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   chk_lead_low:
      assert property (mst && $rose(SERIAL_CLOCK_PIN_O)
         |-> lo_cnt == (rises == 4'h0 ? h2 + l2 : l2))
         else $error("select lead or low phase wrong");
   chk_high_width:
      assert property (mst && $fell(SERIAL_CLOCK_PIN_O) |-> hi_cnt == h2)
         else $error("high phase wrong");
   chk_trail_hold:
      assert property (mst && $rose(TX_FRAME_SELECT_PIN_O) |-> lo_cnt == l2 && rises == 4'h8)
         else $error("select trail wrong");
   chk_first_bit:
      assert property (mst && $fell(SERIAL_DATA_OUT_OE_B) |-> lo_cnt == h2 && rises == 4'h0)
         else $error("first bit timing wrong");
   chk_data_release:
      assert property (mst && $rose(SERIAL_DATA_OUT_OE_B)
         |-> $fell(SERIAL_CLOCK_PIN_O) && rises == 4'h8) else $error("data release wrong");
   chk_shift_fall:
      assert property (mst && !SERIAL_DATA_OUT_OE_B && !$past(SERIAL_DATA_OUT_OE_B)
         && $changed(SERIAL_DATA_OUT_O) |-> $fell(SERIAL_CLOCK_PIN_O)) else $error("data moved");
   chk_clock_stop:
      assert property (mst && TX_FRAME_SELECT_PIN_O |-> !SERIAL_CLOCK_PIN_O)
         else $error("clock runs outside frame");
   chk_drivers_on:
      assert property (mst && $past(CONFIG_OK)
         |-> !SERIAL_CLOCK_PIN_OE_B && !TX_FRAME_SELECT_PIN_OE_B)
         else $error("master pins not driven");
   chk_select_idle:
      assert property (mst && !BUSY && !$past(BUSY)
         |-> TX_FRAME_SELECT_PIN_O == CFG.tx_frame_polarity)
         else $error("idle select level wrong");
   chk_rx_pulse:
      assert property (mst && $rose(SERIAL_CLOCK_PIN_O) && rises == 4'h7 |-> RX_VALID)
         else $error("receive pulse missing");
endmodule : spi_port_asserts
bind spi_clock_stop_port spi_port_asserts chk (.CLK_SYS, .RST_B, .CFG, .SERIAL_CLOCK_PIN_O,
   .SERIAL_CLOCK_PIN_OE_B, .TX_FRAME_SELECT_PIN_O, .TX_FRAME_SELECT_PIN_OE_B,
   .SERIAL_DATA_OUT_O, .SERIAL_DATA_OUT_OE_B, .RX_VALID, .CONFIG_OK, .BUSY);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import spi_cs_pkg::*;
   typedef struct packed {logic [7:0] div; logic [7:0] tx; logic [7:0] rx; logic chk;} row_t;
   localparam cfg_t mst_cfg = '{STOP_MODE_HALF, CLK_POL_IDLE_LOW, FRAME_POL_LOW, FRAME_POL_LOW,
      1'h1, 1'h1, 1'h0, 1'h0, SRC_INTERNAL, 8'h05};
   localparam cfg_t slv_cfg = '{STOP_MODE_HALF, CLK_POL_IDLE_LOW, FRAME_POL_LOW, FRAME_POL_LOW,
      1'h0, 1'h0, 1'h0, 1'h0, SRC_INTERNAL, SLAVE_DIV};
   // the input synchroniser needs five clocks of setup, so receive is judged from div 5 up
   localparam row_t rows [8] = '{'{8'h00, 8'h81, 8'h7E, 1'h0}, '{8'h01, 8'h42, 8'hBD, 1'h0},
      '{8'h02, 8'h24, 8'hDB, 1'h0}, '{8'h03, 8'hF0, 8'h0F, 1'h0}, '{8'h04, 8'h3C, 8'hC3, 1'h0},
      '{8'h05, 8'h01, 8'hFE, 1'h1}, '{8'h06, 8'h5A, 8'hA5, 1'h1}, '{8'h07, 8'h99, 8'h66, 1'h1}};
   logic              CLK_SYS  = 1'h1;
   logic              RST_B    = 1'h1;
   cfg_t              CFG      = mst_cfg;
   logic [WORD_W-1:0] TX_DATA  = '0;
   logic              TX_VALID = 1'h0;
   logic              m_sclk   = 1'h0;
   logic              m_sel_b  = 1'h1;
   logic              m_din    = 1'h0;
   logic              ext_clk  = 1'h0;
   logic [7:0]        peer_tx  = 8'h00;
   logic [WORD_W-1:0] RX_DATA;
   logic [7:0]        got;
   logic              TX_READY, RX_VALID, sclk_o, sclk_oe_b, sel_o, sel_oe_b, dout_o, dout_oe_b;
   logic              CONFIG_OK, BUSY, miso;
   int                errors = 0, cmp_count = 0, cyc = 0, frames = 0, rx_n = 0;
   // pin levels from whichever side drives them
   wire logic         sclk_w = sclk_oe_b ? m_sclk : sclk_o;
   wire logic         sel_w  = sel_oe_b ? m_sel_b : sel_o;
   wire logic         dout_w = dout_oe_b ? 1'hz : dout_o;
   wire logic         din_w  = CFG.tx_clock_dir ? miso : m_din;
   spi_clock_stop_port dut (.CLK_SYS, .RST_B, .CFG, .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA,
      .RX_VALID, .SERIAL_CLOCK_PIN_I(sclk_w), .SERIAL_CLOCK_PIN_O(sclk_o),
      .SERIAL_CLOCK_PIN_OE_B(sclk_oe_b), .TX_FRAME_SELECT_PIN_I(sel_w),
      .TX_FRAME_SELECT_PIN_O(sel_o), .TX_FRAME_SELECT_PIN_OE_B(sel_oe_b), .RX_FRAME_PIN_I(sel_w),
      .SERIAL_DATA_OUT_O(dout_o), .SERIAL_DATA_OUT_OE_B(dout_oe_b), .SERIAL_DATA_IN(din_w),
      .SRG_EXT_CLK_IN(ext_clk), .CONFIG_OK, .BUSY);
   spi_peer peer (.sclk(sclk_w), .sel_b(sel_w), .mosi(dout_w), .tx_word(peer_tx), .miso, .got);
   always #2 CLK_SYS = ~CLK_SYS;
   always @(posedge sel_w) frames++;
   // whole run needs about 2000 cycles; the ceiling leaves wide margin
   always @(posedge CLK_SYS) begin
      rx_n += (RX_VALID === 1'h1);
      // external sample-rate clock of four system clocks
      ext_clk <= ext_clk ^ cyc[0];
      cyc++;
      if (cyc == 6000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end
   task automatic cmp_w(input logic [7:0] exp, input logic [7:0] act);
      cmp_count++;
      if (act !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : cmp_w
   task automatic cmp_f(input logic exp, input logic act);
      cmp_w({7'h0, exp}, {7'h0, act});
   endtask : cmp_f
   task automatic restart(input cfg_t c);
      CFG   <= c;
      RST_B <= 1'h0;
      repeat (10) @(posedge CLK_SYS);
      RST_B <= 1'h1;
      repeat (2) @(posedge CLK_SYS);
   endtask : restart
   // leaves valid high so words can follow back to back
   task automatic push(input logic [7:0] w);
      TX_DATA  <= w;
      TX_VALID <= 1'h1;
      do @(negedge CLK_SYS); while (TX_READY !== 1'h1);
      @(posedge CLK_SYS);
   endtask : push
   task automatic results;
      $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      cfg_t bad;
      int   f0, r0;
      // illegal mode: nothing moves, fifo fills and refuses a ninth word
      bad = mst_cfg;
      bad.clock_stop_mode = 2'h2;
      restart(bad);
      for (int k = 0; k < FIFO_DEPTH; k++) push(8'hA0 + k[7:0]);
      TX_DATA <= 8'hFF;
      repeat (4) @(negedge CLK_SYS);
      cmp_f(1'h0, TX_READY);
      cmp_f(1'h0, CONFIG_OK);
      cmp_f(1'h1, sclk_oe_b & sel_oe_b & dout_oe_b);
      @(posedge CLK_SYS);
      TX_VALID <= 1'h0;
      CFG      <= mst_cfg;
      f0 = frames;
      peer_tx = 8'hC3;
      // drain back to back, msb first, in order
      for (int k = 0; k < FIFO_DEPTH; k++) begin
         @(posedge sel_w);
         cmp_w(8'hA0 + k[7:0], got);
         cmp_w(8'hC3, RX_DATA);
      end
      repeat (200) @(posedge CLK_SYS);
      cmp_w(8'h08, 8'(frames - f0));
      cmp_f(1'h1, TX_READY);
      $display("test fill and drain done");
      foreach (rows[i]) begin
         CFG.clock_divide_value <= rows[i].div;
         peer_tx = rows[i].rx;
         push(rows[i].tx);
         TX_VALID <= 1'h0;
         @(posedge sel_w);
         cmp_w(rows[i].tx, got);
         if (rows[i].chk) cmp_w(rows[i].rx, RX_DATA);
         repeat (3) @(posedge CLK_SYS);
         $display("test divider %0d done", rows[i].div);
      end
      // external source: half-S is one external edge, so a frame takes twice as long
      CFG.srg_clock_source_sel <= 1'h0;
      CFG.clock_divide_value   <= 8'h03;
      peer_tx = 8'h5A;
      push(8'hA5);
      TX_VALID <= 1'h0;
      f0 = cyc;
      @(posedge sel_w);
      cmp_w(8'hA5, got);
      cmp_w(8'h5A, RX_DATA);
      cmp_w(8'h01, 8'((cyc - f0) / 128));
      repeat (3) @(posedge CLK_SYS);
      $display("test external clock done");
      // slave: the bench is the master, half period of 8 system clocks
      restart(slv_cfg);
      r0 = rx_n;
      push(8'h96);
      TX_VALID <= 1'h0;
      cmp_f(1'h1, sclk_oe_b);
      cmp_f(1'h1, dout_oe_b);
      m_sel_b <= 1'h0;
      for (int b = 7; b >= 0; b--) begin
         m_din <= b[7:0] inside {8'h05, 8'h04, 8'h03, 8'h02};
         repeat (8) @(posedge CLK_SYS);
         m_sclk <= 1'h1;
         repeat (8) @(posedge CLK_SYS);
         m_sclk <= 1'h0;
      end
      repeat (8) @(posedge CLK_SYS);
      cmp_f(1'h1, dout_oe_b);
      m_sel_b <= 1'h1;
      m_din   <= 1'h1;
      repeat (8) @(posedge CLK_SYS);
      cmp_w(8'h96, got);
      cmp_w(8'h3C, RX_DATA);
      cmp_w(8'h01, 8'(rx_n - r0));
      $display("test slave done");
      results();
   end
endmodule : testbench
`default_nettype wire
